// File: include/fsc_pkg.sv
/*
 File: constants of the host for the serial flash auxiliary commands.
 Assumes: one 250 MHz clock; the flash is reached only through its pins.
*/
// Notes on behaviour
// R1: Id read 4Bh: address, dummy clocks, 16 id bytes.
// R2: Id bytes repeat while selected and clocked.
// R3: Id start byte is address 3..0; bits 8..4 zero.
// R4: Table read 5Ah: address, dummy clocks, stop any time.
// R5: Undefined table bytes carry no meaning.
// R6: Quad reads keep quad framing; only opcode differs.
// R7: Opcode 00h only cancels a reset arm.
// R8: Soft reset: 66h in one frame, 99h in the next.
// R9: Any other opcode cancels the arm.
// R10: Reset pin honoured per pin configuration.
// R11: Reset pin low at least 1 us.
// R12: Reset pin overrides all inputs.
// R13: No command within 100 us of a pin reset.
// R14: Reset aborts a running program or erase.
// R15: Row program refused during a write cycle.
// R16: Row address 00h, then 00h, 10h, 20h or 30h.
// R17: Function bits 7..4 lock rows read-only.
// R18: Row erase 64h needs write enable; latch clears.
// R19: Row erase starts on select rise after address.
// R20: Row program 62h: address, 1 to 256 bytes.
// R21: While programming only status read works.
// R22: Over 256 bytes wraps in page; last 256 kept.
// R23: Row read 68h: address, dummy, falling-edge data.
// R24: Past a row end data is meaningless.
// R25: Row read ignored during a write cycle.
package fsc_pkg;
   // =====================================================
   // Opcodes
   localparam logic [7:0] OP_UID      = 8'h4b;
   localparam logic [7:0] OP_PTABLE   = 8'h5a;
   localparam logic [7:0] OP_NOP      = 8'h00;
   localparam logic [7:0] OP_RST_ARM  = 8'h66;
   localparam logic [7:0] OP_RST_GO   = 8'h99;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD     = 8'h06;
   localparam logic [7:0] OP_READ_STATUS_CMD     = 8'h05;
   localparam logic [7:0] OP_ROW_ER   = 8'h64;
   localparam logic [7:0] OP_ROW_PG   = 8'h62;
   localparam logic [7:0] OP_ROW_RD   = 8'h68;
   // =====================================================
   // Software register map (word addresses)
   localparam logic [3:0] A_CTRL      = 4'h0;
   localparam logic [3:0] A_ADDR      = 4'h1;
   localparam logic [3:0] A_WDATA     = 4'h2;
   localparam logic [3:0] A_RDATA     = 4'h3;
   localparam logic [3:0] A_STAT      = 4'h4;
   localparam logic [3:0] A_COUNT     = 4'h5;
   localparam logic [3:0] A_DUMMY     = 4'h6;
   // Control fields
   localparam int CTRL_GO      = 0;
   localparam int CTRL_KIND_LO = 1;
   localparam int CTRL_QUAD    = 5;
   localparam int CTRL_HWRST   = 6;
   // Command kinds
   localparam logic [3:0] K_UID    = 4'h0;
   localparam logic [3:0] K_PTABLE = 4'h1;
   localparam logic [3:0] K_NOP    = 4'h2;
   localparam logic [3:0] K_ARM    = 4'h3;
   localparam logic [3:0] K_RST    = 4'h4;
   localparam logic [3:0] K_WRITE_ENABLE_CMD   = 4'h5;
   localparam logic [3:0] K_READ_STATUS_CMD   = 4'h6;
   localparam logic [3:0] K_ROW_ER = 4'h7;
   localparam logic [3:0] K_ROW_PG = 4'h8;
   localparam logic [3:0] K_ROW_RD = 4'h9;
   // Status fields
   localparam int ST_BUSY   = 0;
   localparam int ST_RVALID = 1;
   localparam int ST_WFULL  = 2;
   localparam int ST_HOLD   = 3;
   // =====================================================
   // Timing
   localparam int    CLK_MHZ         = 250;
   localparam int    T_RESET_NS      = 1000;
   localparam int    T_HWRST_NS      = 100000;
   localparam int    RESET_CYC       = (T_RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int    HWRST_CYC       = (T_HWRST_NS * CLK_MHZ + 999) / 1000;
   localparam int    SCK_HALF_DIV    = 20;
   localparam logic [7:0] DUMMY_RST  = 8'h08;
   localparam int    PAGE_BYTES      = 256;
endpackage

// File: include/fsc_sh_if.sv
/*
 File: link between the sequencer and its serial shifter.
 Assumes: both ends on mclk.
*/
`timescale 1ns/1ps
interface fsc_sh_if;
   logic       start;
   logic       quad;
   logic       rx;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic       done;
   modport seq (output start, quad, rx, tx_byte, input rx_byte, done);
   modport sh  (input start, quad, rx, tx_byte, output rx_byte, done);
endinterface

// File: verilog/fsc_tick.sv
/*
 File: divider making one-cycle half-period enable pulses for the serial clock.
 Assumes: free-running mclk; en gates the count.
*/
`timescale 1ns/1ps
module fsc_tick #(
   parameter int DIV = fsc_pkg::SCK_HALF_DIV
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // control
   input  wire logic en,
   output logic      tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } fsc_tick_s;
   fsc_tick_s st_reg, st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (!en) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt == 8'(DIV - 1)) begin
         st_next.cnt  = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;
endmodule

// File: verilog/fsc_shift.sv
/*
 File: byte shifter for single-line or quad-line flash framing, mode 0.
 Assumes: tick is a half-period enable; the sequencer keeps select low around bytes.
 Output changes after a falling edge; input sampled at the rising edge.
*/
`timescale 1ns/1ps
module fsc_shift (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // pacing
   input  wire logic tick,
   // sequencer side
   fsc_sh_if.sh      sh,
   // pins (data already synchronised)
   input  wire logic [3:0] io_in_sync,
   output logic            sck,
   output logic [3:0]      io_out,
   output logic [3:0]      io_oe
);
   typedef struct packed {
      logic       busy;
      logic       sck;
      logic [7:0] sr;
      logic [3:0] edges;
      logic [3:0] out;
      logic [3:0] oe;
      logic       quad;
      logic       rx;
      logic       done;
   } fsc_shift_s;
   fsc_shift_s st_reg, st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      if (!st_reg.busy) begin
         if (sh.start) begin
            st_next.busy  = 1'b1;
            st_next.quad  = sh.quad;
            st_next.rx    = sh.rx;
            st_next.sr    = sh.tx_byte;
            st_next.edges = sh.quad ? 4'd2 : 4'd8;
            if (sh.rx) begin
               st_next.oe = 4'h0;
            end else if (sh.quad) begin
               st_next.oe  = 4'hf;
               st_next.out = sh.tx_byte[7:4];
            end else begin
               st_next.oe  = 4'h1;
               st_next.out = {3'b000, sh.tx_byte[7]};
            end
         end
      end else if (tick) begin
         st_next.sck = ~st_reg.sck;
         if (!st_reg.sck) begin
            // Rising edge: sample input lines
            if (st_reg.quad) begin
               st_next.sr = {st_reg.sr[3:0], io_in_sync};
            end else begin
               st_next.sr = {st_reg.sr[6:0], io_in_sync[1]};
            end
            st_next.edges = st_reg.edges - 4'd1;
         end else if (st_reg.edges == 4'd0) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.oe   = 4'h0;
         end else if (!st_reg.rx) begin
            st_next.out = st_reg.quad ? st_reg.sr[7:4] : {3'b000, st_reg.sr[7]};
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sck        = st_reg.sck;
   assign io_out     = st_reg.out;
   assign io_oe      = st_reg.oe;
   assign sh.rx_byte = st_reg.sr;
   assign sh.done    = st_reg.done;
endmodule

// File: verilog/fsc_host.sv
/*
 File: host controller that issues the auxiliary flash commands from a software register port.
 Assumes: the flash answers per its framing; data pins come from another domain and are
 synchronised here. Software starts one command at a time and polls the busy bit.
*/
`timescale 1ns/1ps
module fsc_host #(
   parameter int HWRST_WAIT = fsc_pkg::HWRST_CYC,
   parameter int RESET_LOW  = fsc_pkg::RESET_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // software register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // flash pins
   output logic             ce_n,
   output logic             sck,
   output logic             reset_n,
   input  wire logic [3:0]  io_in,
   output logic [3:0]       io_out,
   output logic [3:0]       io_oe
);
   typedef enum logic [3:0] {
      S_IDLE, S_OPC, S_ADDR, S_DUMMY, S_WDATA, S_RDATA, S_END, S_RSTLOW, S_RSTWAIT
   } fsc_state_e;

   typedef struct packed {
      fsc_state_e  state;
      logic [3:0]  kind;
      logic        quad;
      logic [23:0] addr;
      logic [7:0]  wbuf;
      logic        wfull;
      logic [7:0]  rbuf;
      logic        rvalid;
      logic [8:0]  count;
      logic [8:0]  left;
      logic [1:0]  abyte;
      logic [7:0]  dummy;
      logic [7:0]  dleft;
      logic        hold;
      logic        started;
      logic [16:0] wait_cnt;
      logic        ce_n;
      logic        reset_n;
      logic [31:0] rdata;
      logic [3:0]  io_s1;
      logic [3:0]  io_s2;
   } fsc_host_s;
   fsc_host_s st_reg, st_next;


   fsc_sh_if sh_bus();
   logic tick;
   logic [3:0] sh_out, sh_oe;
   logic sh_sck;

   // =====================================================
   // Helpers
   function automatic logic [7:0] kind_op(input logic [3:0] k);
      unique case (k)
         fsc_pkg::K_UID:    kind_op = fsc_pkg::OP_UID;                  // [R1]
         fsc_pkg::K_PTABLE: kind_op = fsc_pkg::OP_PTABLE;               // [R4]
         fsc_pkg::K_NOP:    kind_op = fsc_pkg::OP_NOP;                  // [R7]
         fsc_pkg::K_ARM:    kind_op = fsc_pkg::OP_RST_ARM;              // [R8]
         fsc_pkg::K_RST:    kind_op = fsc_pkg::OP_RST_GO;               // [R8]
         fsc_pkg::K_WRITE_ENABLE_CMD:   kind_op = fsc_pkg::OP_WRITE_ENABLE_CMD;                 // [R18]
         fsc_pkg::K_READ_STATUS_CMD:   kind_op = fsc_pkg::OP_READ_STATUS_CMD;                 // [R21]
         fsc_pkg::K_ROW_ER: kind_op = fsc_pkg::OP_ROW_ER;               // [R18]
         fsc_pkg::K_ROW_PG: kind_op = fsc_pkg::OP_ROW_PG;               // [R20]
         fsc_pkg::K_ROW_RD: kind_op = fsc_pkg::OP_ROW_RD;               // [R23]
         default:           kind_op = fsc_pkg::OP_NOP;
      endcase
   endfunction

   function automatic logic has_addr(input logic [3:0] k);
      has_addr = (k == fsc_pkg::K_UID) || (k == fsc_pkg::K_PTABLE) || (k == fsc_pkg::K_ROW_ER)
              || (k == fsc_pkg::K_ROW_PG) || (k == fsc_pkg::K_ROW_RD);
   endfunction

   function automatic logic is_read(input logic [3:0] k);
      is_read = (k == fsc_pkg::K_UID) || (k == fsc_pkg::K_PTABLE) || (k == fsc_pkg::K_ROW_RD);
   endfunction

   // Row address as the flash expects it: top byte 00h, middle byte row*10h
   function automatic logic [23:0] row_addr(input logic [23:0] a);
      row_addr = {8'h00, 2'b00, a[13:12], 4'h0, a[7:0]};                // [R16]
   endfunction

   // =====================================================
   // Sequencer
   always_comb begin
      st_next            = st_reg;

      st_next.io_s1      = io_in;
      st_next.io_s2      = st_reg.io_s1;
      st_next.rdata      = 32'h0000_0000;
      sh_bus.start       = 1'b0;
      sh_bus.rx          = 1'b0;
      sh_bus.quad        = st_reg.quad;
      sh_bus.tx_byte     = 8'h00;

      if (reg_rd) begin
         unique case (reg_addr)
            fsc_pkg::A_CTRL:  st_next.rdata = {25'h0, st_reg.quad, 1'b0, st_reg.kind, 1'b0};
            fsc_pkg::A_ADDR:  st_next.rdata = {8'h00, st_reg.addr};
            fsc_pkg::A_RDATA: begin
               st_next.rdata  = {24'h0, st_reg.rbuf};
               st_next.rvalid = 1'b0;
            end
            fsc_pkg::A_STAT:  st_next.rdata = {28'h0, st_reg.hold, st_reg.wfull, st_reg.rvalid,
                                               st_reg.state != S_IDLE};
            fsc_pkg::A_COUNT: st_next.rdata = {23'h0, st_reg.count};
            fsc_pkg::A_DUMMY: st_next.rdata = {24'h0, st_reg.dummy};
            default:          st_next.rdata = 32'h0000_0000;
         endcase
      end

      if (reg_wr) begin
         unique case (reg_addr)
            fsc_pkg::A_ADDR:  st_next.addr = reg_wdata[23:0];
            fsc_pkg::A_WDATA: begin
               st_next.wbuf  = reg_wdata[7:0];
               st_next.wfull = 1'b1;
            end
            fsc_pkg::A_COUNT: st_next.count = reg_wdata[8:0];
            fsc_pkg::A_DUMMY: st_next.dummy = reg_wdata[7:0];
            fsc_pkg::A_CTRL: begin
               if (st_reg.state == S_IDLE) begin
                  st_next.quad = reg_wdata[fsc_pkg::CTRL_QUAD];
                  if (reg_wdata[fsc_pkg::CTRL_HWRST]) begin
                     st_next.state   = S_RSTLOW;
                     st_next.reset_n = 1'b0;
                     st_next.ce_n    = 1'b1;
                     st_next.wait_cnt = 17'(RESET_LOW);                 // [R11]
                  end else if (reg_wdata[fsc_pkg::CTRL_GO] && !st_reg.hold) begin
                     st_next.kind    = reg_wdata[fsc_pkg::CTRL_KIND_LO +: 4];
                     st_next.state   = S_OPC;
                     st_next.ce_n    = 1'b0;
                     st_next.started = 1'b0;
                  end
               end
            end
            default: ;
         endcase
      end


      unique case (st_reg.state)

         S_IDLE: ;

         S_OPC: begin
            if (!st_reg.started) begin
               sh_bus.start    = 1'b1;
               sh_bus.tx_byte  = kind_op(st_reg.kind);                  // [R6]
               st_next.started = 1'b1;
            end else if (sh_bus.done) begin
               st_next.started = 1'b0;
               st_next.abyte   = 2'd0;
               st_next.dleft   = st_reg.dummy;

               st_next.left    = (st_reg.count == 9'd0) ? 9'd1 : st_reg.count;
               if (st_reg.kind == fsc_pkg::K_ROW_PG && st_reg.count > 9'(fsc_pkg::PAGE_BYTES)) begin
                  st_next.left = 9'(fsc_pkg::PAGE_BYTES);               // [R22]
               end
               if (st_reg.kind == fsc_pkg::K_UID) begin
                  st_next.addr = {st_reg.addr[23:9], 5'b00000, st_reg.addr[3:0]}; // [R3]
               end else if (st_reg.kind == fsc_pkg::K_ROW_ER || st_reg.kind == fsc_pkg::K_ROW_PG
                            || st_reg.kind == fsc_pkg::K_ROW_RD) begin
                  st_next.addr = row_addr(st_reg.addr);
               end
               st_next.state = has_addr(st_reg.kind) ? S_ADDR
                             : (st_reg.kind == fsc_pkg::K_READ_STATUS_CMD) ? S_RDATA : S_END;
            end
         end

         S_ADDR: begin
            if (!st_reg.started) begin
               sh_bus.start    = 1'b1;
               sh_bus.tx_byte  = st_reg.addr[23:16];
               st_next.started = 1'b1;
            end else if (sh_bus.done) begin
               st_next.started = 1'b0;
               st_next.addr    = {st_reg.addr[15:0], st_reg.addr[23:16]};
               st_next.abyte   = st_reg.abyte + 2'd1;
               if (st_reg.abyte == 2'd2) begin
                  st_next.state = is_read(st_reg.kind) ? S_DUMMY     // [R1] [R4] [R23]
                                : (st_reg.kind == fsc_pkg::K_ROW_PG) ? S_WDATA : S_END; // [R19]
               end
            end
         end

         S_DUMMY: begin
            // Dummy clocks counted as whole byte slots of the current line width
            if (st_reg.dleft == 8'd0) begin
               st_next.state = S_RDATA;
            end else if (!st_reg.started) begin
               sh_bus.start    = 1'b1;
               sh_bus.rx       = 1'b1;
               st_next.started = 1'b1;
            end else if (sh_bus.done) begin
               st_next.started = 1'b0;
               st_next.dleft   = (st_reg.dleft > (st_reg.quad ? 8'd2 : 8'd8))
                               ? st_reg.dleft - (st_reg.quad ? 8'd2 : 8'd8) : 8'd0;
            end
         end

         S_WDATA: begin
            if (!st_reg.started && st_reg.wfull) begin
               sh_bus.start    = 1'b1;
               sh_bus.tx_byte  = st_reg.wbuf;                           // [R20]
               // A byte written in this very cycle keeps its flag: set beats clear
               st_next.wfull   = reg_wr && (reg_addr == fsc_pkg::A_WDATA);
               st_next.started = 1'b1;
            end else if (st_reg.started && sh_bus.done) begin
               st_next.started = 1'b0;
               st_next.left    = st_reg.left - 9'd1;
               if (st_reg.left == 9'd1) begin
                  st_next.state = S_END;
               end
            end
         end

         S_RDATA: begin
            // One byte per software fetch; stalls while the last byte is unread
            if (!st_reg.started && !st_reg.rvalid) begin
               sh_bus.start    = 1'b1;
               sh_bus.rx       = 1'b1;
               st_next.started = 1'b1;
            end else if (st_reg.started && sh_bus.done) begin
               st_next.started = 1'b0;
               st_next.rbuf    = sh_bus.rx_byte;                        // [R2] [R5] [R21]
               st_next.rvalid  = 1'b1;
               st_next.left    = st_reg.left - 9'd1;
               if (st_reg.left == 9'd1) begin
                  st_next.state = S_END;                                // [R24]
               end
            end
         end

         S_END: begin
            st_next.ce_n  = 1'b1;                                       // [R19] [R20]
            st_next.state = S_IDLE;
         end

         S_RSTLOW: begin
            if (st_reg.wait_cnt <= 17'd1) begin
               st_next.reset_n  = 1'b1;
               st_next.wait_cnt = 17'(HWRST_WAIT);
               st_next.state    = S_RSTWAIT;
            end else begin
               st_next.wait_cnt = st_reg.wait_cnt - 17'd1;
            end
         end

         S_RSTWAIT: begin
            if (st_reg.wait_cnt <= 17'd1) begin
               st_next.state = S_IDLE;                                  // [R13]
            end else begin
               st_next.wait_cnt = st_reg.wait_cnt - 17'd1;
            end
         end

         default: st_next.state = S_IDLE;
      endcase

      st_next.hold = (st_next.state == S_RSTLOW) || (st_next.state == S_RSTWAIT);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg         <= '0;
         st_reg.state   <= S_IDLE;
         st_reg.ce_n    <= 1'b1;
         st_reg.reset_n <= 1'b1;
         st_reg.dummy   <= fsc_pkg::DUMMY_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // =====================================================
   // Serial engine

   fsc_tick u_tick (
      .mclk (mclk),
      .rst  (rst),
      .en   (st_reg.state != S_IDLE),
      .tick (tick)
   );


   fsc_shift u_shift (
      .mclk       (mclk),
      .rst        (rst),
      .tick       (tick),
      .sh         (sh_bus.sh),
      .io_in_sync (st_reg.io_s2),
      .sck        (sh_sck),
      .io_out     (sh_out),
      .io_oe      (sh_oe)
   );


   assign reg_rdata = st_reg.rdata;
   assign ce_n      = st_reg.ce_n;
   assign reset_n   = st_reg.reset_n;
   assign sck       = sh_sck;
   assign io_out    = sh_out;
   assign io_oe     = sh_oe;
endmodule

// File: dv/fsc_host_monitor.sv
/* Checker on the flash host top ports.
   Assumes: bound to fsc_host; one mclk domain. */
`timescale 1ns/1ps
module fsc_host_monitor #(
   parameter int HWRST_WAIT = 20,
   parameter int RESET_LOW  = 4
) (
   // clock, reset, register port
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // flash pins
   input wire logic        ce_n,
   input wire logic        sck,
   input wire logic        reset_n,
   input wire logic [3:0]  io_in,
   input wire logic [3:0]  io_out,
   input wire logic [3:0]  io_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ==========================================
   // Cycles since the reset pin went high again
   int since_rel;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         since_rel <= HWRST_WAIT;
      else if (!reset_n)
         since_rel <= 0;
      else if (since_rel < HWRST_WAIT)
         since_rel <= since_rel + 1;
   end
   sequence sel_open;
      $fell(ce_n);
   endsequence
   sequence pin_pulse;
      !reset_n [*4] ##[0:2] reset_n;
   endsequence
   idle_clock_a: assert property (ce_n |-> !sck) else $error("clock moves while deselected");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
   pin_pulse_a: assert property ($fell(reset_n) |-> pin_pulse) else $error("reset pulse length wrong");
   reset_quiet_a: assert property (!reset_n |-> ce_n) else $error("select during reset pulse");
   post_reset_a: assert property (sel_open |-> since_rel >= HWRST_WAIT - 2) else $error("command too soon");
   sel_setup_a: assert property (sel_open |-> !sck [*4]) else $error("clock too soon after select");
   data_change_a: assert property ($changed(io_out) && !ce_n |-> !sck) else $error("data moved, clock high");
   clock_high_a: assert property ($rose(sck) |-> sck [*8]) else $error("clock high too short");
   bus_release_a: assert property (ce_n && $past(ce_n) |-> io_oe == 4'h0) else $error("pins driven while idle");
endmodule

// File: dv/fsc_flash_model.sv
/* Behavioural serial flash: single-line framing, four security rows.
   Assumes: mode 0 clock from the host; rows are never locked. */
`timescale 1ns/1ps
module fsc_flash_model (
   // pins from the host
   input wire logic       ce_n,
   input wire logic       sck,
   input wire logic       reset_n,
   input wire logic [3:0] io_out,
   // pins to the host
   output logic [3:0]     io_in
);
   logic [7:0]  mem [1024];
   logic [31:0] f;
   logic [7:0]  op, by;
   logic [23:0] addr;
   logic        armed = 1'b0, write_enable_latch = 1'b0, drv = 1'b0, bit_o = 1'b0;
   int          bitcnt, k, n_sw_rst = 0, n_hw_rst = 0;
   // ==========================================
   // Released line shows the inverse of its last bit
   assign io_in = {2'b11, (drv && !ce_n && reset_n) ? bit_o : ~bit_o, io_out[0]};
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(negedge ce_n) begin
      bitcnt = 0;
      drv = 1'b0;
   end
   always @(negedge reset_n) begin
      n_hw_rst++;
      armed = 1'b0;
      write_enable_latch = 1'b0;
   end
   always @(posedge sck) if (!ce_n && reset_n) begin
      f = {f[30:0], io_out[0]};
      bitcnt++;
      if (bitcnt == 8) op = f[7:0];
      if (bitcnt == 32) addr = f[23:0];
      if (op == 8'h62 && write_enable_latch && bitcnt >= 40 && bitcnt % 8 == 0)
         mem[{addr[13:12], 8'(addr[7:0] + (bitcnt - 40) / 8)}] &= f[7:0];
   end
   always @(posedge ce_n) begin
      if (bitcnt == 8 && op == 8'h99 && armed) n_sw_rst++;
      if (bitcnt == 8 && op == 8'h06) write_enable_latch = 1'b1;
      if (op == 8'h64 && bitcnt == 32 && write_enable_latch)
         for (int i = 0; i < 256; i++) mem[{addr[13:12], 8'(i)}] = 8'hff;
      if (op == 8'h64 || op == 8'h62) write_enable_latch = 1'b0;
      armed = (bitcnt == 8 && op == 8'h66);
   end
   always @(negedge sck) if (!ce_n && reset_n && bitcnt >= 40 && op != 8'h62) begin
      k = (bitcnt - 40) / 8;
      by = (op == 8'h4b) ? 8'h30 + 8'((addr[3:0] + k) % 16) :
           (op == 8'h5a) ? 8'hc0 ^ 8'(addr[7:0] + k) : mem[{addr[13:12], 8'(addr[7:0] + k)}];
      bit_o = by[7 - (bitcnt - 40) % 8];
      drv = 1'b1;
   end
endmodule

// File: dv/tb.sv
/* Self-checking bench: register tasks issue commands, the flash model answers.
   Assumes: package, host and model compiled first. */
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic        ce_n, sck, reset_n;
   logic [3:0]  io_in, io_out, io_oe;
   int          n_errors = 0, n_tests = 0;
   logic [3:0]  kt [6] = '{4'h3, 4'h4, 4'h3, 4'h2, 4'h4, 4'h5};
   logic [7:0]  ot [6] = '{8'h66, 8'h99, 8'h66, 8'h00, 8'h99, 8'h06};
   always #2 mclk = ~mclk;
   fsc_host #(.HWRST_WAIT(20), .RESET_LOW(4)) fsc_host_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ce_n(ce_n),
      .sck(sck), .reset_n(reset_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   fsc_flash_model fsc_flash_model_i (.ce_n(ce_n), .sck(sck), .reset_n(reset_n), .io_out(io_out), .io_in(io_in));
   // ==========================================
   // Register port tasks
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic wait_st(input int b, input logic v);
      for (int i = 0; i < 2000; i++) begin
         rd(fsc_pkg::A_STAT);
         if (d[b] === v) return;
      end
      chk("status wait", 1, 0);
      tally_and_finish();
   endtask
   task automatic run(input logic [3:0] kind);
      wr(fsc_pkg::A_CTRL, {27'h0, kind, 1'b1});
   endtask
   task automatic rdb(input string s, input logic [7:0] e);
      wait_st(fsc_pkg::ST_RVALID, 1'b1);
      rd(fsc_pkg::A_RDATA);
      chk(s, d, {24'h0, e});
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd(fsc_pkg::A_DUMMY);
      chk("dummy", d, 32'h8);
      rd(4'hf);
      chk("unmapped", d, 32'h0);
      wr(fsc_pkg::A_ADDR, 32'h12345e);
      wr(fsc_pkg::A_COUNT, 32'h12);
      run(fsc_pkg::K_UID);
      for (int k = 0; k < 18; k++) rdb("uid", 8'h30 + 8'((k + 14) % 16));
      wait_st(fsc_pkg::ST_BUSY, 1'b0);
      chk("uid addr", fsc_flash_model_i.addr[8:0], 32'h00e);
      $display("unique id test done");
      foreach (kt[i]) begin
         run(kt[i]);
         wait_st(fsc_pkg::ST_BUSY, 1'b0);
         chk("opcode", fsc_flash_model_i.op, ot[i]);
      end
      chk("soft resets", fsc_flash_model_i.n_sw_rst, 1);
      $display("reset command test done");
      wr(fsc_pkg::A_ADDR, 32'h2010);
      run(fsc_pkg::K_ROW_ER);
      wait_st(fsc_pkg::ST_BUSY, 1'b0);
      chk("row addr", fsc_flash_model_i.addr, 32'h002010);
      run(fsc_pkg::K_WRITE_ENABLE_CMD);
      wait_st(fsc_pkg::ST_BUSY, 1'b0);
      wr(fsc_pkg::A_COUNT, 32'h3);
      for (int k = 0; k < 3; k++) begin
         wait_st(fsc_pkg::ST_WFULL, 1'b0);
         wr(fsc_pkg::A_WDATA, 32'ha0 + k);
         if (k == 0) run(fsc_pkg::K_ROW_PG);
      end
      wait_st(fsc_pkg::ST_BUSY, 1'b0);
      wr(fsc_pkg::A_COUNT, 32'h4);
      run(fsc_pkg::K_ROW_RD);
      for (int k = 0; k < 4; k++) rdb("row", (k < 3) ? 8'(8'ha0 + k) : 8'hff);
      wait_st(fsc_pkg::ST_BUSY, 1'b0);
      $display("security row test done");
      wr(fsc_pkg::A_CTRL, 32'h40);
      wait_st(fsc_pkg::ST_HOLD, 1'b0);
      chk("hard resets", fsc_flash_model_i.n_hw_rst, 1);
      wr(fsc_pkg::A_ADDR, 32'h10);
      wr(fsc_pkg::A_COUNT, 32'h2);
      run(fsc_pkg::K_PTABLE);
      for (int k = 0; k < 2; k++) rdb("table", 8'hd0 + 8'(k));
      wait_st(fsc_pkg::ST_BUSY, 1'b0);
      $display("reset pin and table test done");
      tally_and_finish();
   end
endmodule
bind fsc_host fsc_host_monitor #(.HWRST_WAIT(HWRST_WAIT), .RESET_LOW(RESET_LOW)) fsc_host_monitor_i (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ce_n(ce_n), .sck(sck), .reset_n(reset_n), .io_in(io_in), .io_out(io_out),
   .io_oe(io_oe));
